/* include/mmu_pkg.sv */
package mmu_pkg;
   localparam int          WORD_W      = 16;
   localparam int          ACC_W       = 40;
   localparam int          REG_CNT     = 16;
   localparam logic [7:0]  OPC_MUL     = 8'hB8;
   localparam int          OPC_LO      = 16;
   localparam int          FORM_BIT    = 15;
   localparam int          W_LO        = 11;
   localparam int          D_LO        = 7;
   localparam int          P_LO        = 4;
   localparam int          S_LO        = 0;
   localparam int          ACC_MARK_LO = 8;
   localparam logic [2:0]  ACC_MARK    = 3'h7;
   localparam int          ACC_SEL_BIT = 7;
   localparam int          LIT_MARK_LO = 5;
   localparam logic [1:0]  LIT_MARK    = 2'h3;
   localparam int          IF_BIT      = 0;
   localparam logic [2:0]  AM_DIRECT   = 3'h0;
   localparam logic [2:0]  AM_INDIRECT = 3'h1;
   localparam logic [2:0]  AM_POSTDEC  = 3'h2;
   localparam logic [2:0]  AM_POSTINC  = 3'h3;
   localparam logic [2:0]  AM_PREDEC   = 3'h4;
   localparam logic [2:0]  AM_PREINC   = 3'h5;
   localparam logic [3:0]  LAST_DEST   = 4'hC;
   localparam logic [15:0] PTR_STEP    = 16'h0002;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [3:0]  IDX_RST     = 4'h0;
   localparam logic [39:0] ACC_RST     = 40'h00_0000_0000;

   // decoded operation, one-hot
   typedef enum logic [5:0] {
      OP_NONE    = 6'b000001,
      OP_US_PAIR = 6'b000010,
      OP_US_ACC  = 6'b000100,
      OP_UU_LIT  = 6'b001000,
      OP_UU_PAIR = 6'b010000,
      OP_BAD     = 6'b100000
   } mmu_op_type;
endpackage : mmu_pkg

/* verilog/mmu_multiplier.sv */
module mmu_multiplier #(
   parameter int WORD_W = mmu_pkg::WORD_W,
   parameter int ACC_W  = mmu_pkg::ACC_W,
   parameter int REGS   = mmu_pkg::REG_CNT
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   instrValid,
   input  wire logic [23:0]            instrWord,
   input  wire logic [REGS*WORD_W-1:0] workRegs,
   input  wire logic [WORD_W-1:0]      srcMemData,
   input  wire logic [WORD_W-1:0]      coreControlReg,
   input  wire logic [1:0]             multiplierSignMode,
   output logic                        wrLoEn_ff,
   output logic [3:0]                  wrLoAddr_ff,
   output logic [WORD_W-1:0]           wrLoData_ff,
   output logic                        wrHiEn_ff,
   output logic [3:0]                  wrHiAddr_ff,
   output logic [WORD_W-1:0]           wrHiData_ff,
   output logic                        ptrWrEn_ff,
   output logic [3:0]                  ptrWrAddr_ff,
   output logic [WORD_W-1:0]           ptrWrData_ff,
   output logic [ACC_W-1:0]            accumulatorA_ff,
   output logic [ACC_W-1:0]            accumulatorB_ff,
   output logic                        opDone_ff,
   output logic                        opIllegal_ff
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------

   // pick one working register out of the flat array
   function automatic logic [WORD_W-1:0] regSel(
      input logic [REGS*WORD_W-1:0] regs,
      input logic [3:0]             idx
   );
      regSel = regs[idx*WORD_W +: WORD_W];
   endfunction : regSel

   // true for the four pointer-updating source modes
   function automatic logic modeUpdates(input logic [2:0] mode);
      modeUpdates = (mode == mmu_pkg::AM_POSTDEC) || (mode == mmu_pkg::AM_POSTINC) ||
                    (mode == mmu_pkg::AM_PREDEC)  || (mode == mmu_pkg::AM_PREINC);
   endfunction : modeUpdates

   // -------------------------------------------------------------------
   // instruction field split
   // -------------------------------------------------------------------

   logic       opcMatch;
   logic       formBit;
   logic [3:0] baseIdx;
   logic [3:0] destIdx;
   logic [2:0] srcMode;
   logic [3:0] srcIdx;
   logic       accSel;
   logic [4:0] shortLiteral;
   logic       accMarked;
   logic       litMarked;
   logic       modeLegal;
   logic       destLegal;

   // field positions from the shared encoding
   assign opcMatch     = instrWord[23:mmu_pkg::OPC_LO] == mmu_pkg::OPC_MUL;
   assign formBit      = instrWord[mmu_pkg::FORM_BIT];
   assign baseIdx      = instrWord[mmu_pkg::W_LO +: 4];
   assign destIdx      = instrWord[mmu_pkg::D_LO +: 4];
   assign srcMode      = instrWord[mmu_pkg::P_LO +: 3];
   assign srcIdx       = instrWord[mmu_pkg::S_LO +: 4];
   assign accSel       = instrWord[mmu_pkg::ACC_SEL_BIT];
   assign shortLiteral = instrWord[4:0];
   assign accMarked    = instrWord[mmu_pkg::ACC_MARK_LO +: 3] == mmu_pkg::ACC_MARK;
   assign litMarked    = instrWord[mmu_pkg::LIT_MARK_LO +: 2] == mmu_pkg::LIT_MARK;
   assign modeLegal    = srcMode <= mmu_pkg::AM_PREINC;
   assign destLegal    = !destIdx[0] && (destIdx <= mmu_pkg::LAST_DEST);

   // -------------------------------------------------------------------
   // operation decode
   // -------------------------------------------------------------------

   mmu_pkg::mmu_op_type opKind;

   // classify the word; only word-sized forms exist
   always_comb begin
      if (!instrValid || !opcMatch) begin
         opKind = mmu_pkg::OP_NONE;
      end else if (formBit) begin
         // unsigned-by-signed into a register pair
         opKind = (modeLegal && destLegal) ? mmu_pkg::OP_US_PAIR : mmu_pkg::OP_BAD;
      end else if (accMarked) begin
         // unsigned-by-signed into an accumulator
         opKind = modeLegal ? mmu_pkg::OP_US_ACC : mmu_pkg::OP_BAD;
      end else if (litMarked) begin
         opKind = destLegal ? mmu_pkg::OP_UU_LIT : mmu_pkg::OP_BAD;
      end else begin
         opKind = destLegal ? mmu_pkg::OP_UU_PAIR : mmu_pkg::OP_BAD;
      end
   end

   // -------------------------------------------------------------------
   // operand fetch and products
   // -------------------------------------------------------------------

   logic        [WORD_W-1:0] baseVal;
   logic        [WORD_W-1:0] srcRegVal;
   logic        [WORD_W-1:0] srcVal;
   logic signed [32:0]       usProd;
   logic signed [32:0]       usScaled;
   logic        [31:0]       uuProd;
   logic        [31:0]       litProd;
   logic        [ACC_W-1:0]  accVal;
   logic                     fracMode;

   // base is register direct, source direct or from memory
   assign baseVal   = regSel(workRegs, baseIdx);
   assign srcRegVal = regSel(workRegs, srcIdx);
   assign srcVal    = (srcMode == mmu_pkg::AM_DIRECT) ? srcRegVal : srcMemData;
   assign fracMode  = coreControlReg[mmu_pkg::IF_BIT];

   // base zero-extended; source sign-extended for usProd, zero-extended otherwise; sign mode never consulted
   assign usProd   = $signed({1'b0, baseVal}) * $signed({srcVal[WORD_W-1], srcVal});
   assign uuProd   = {16'h0000, baseVal} * {16'h0000, srcVal};
   assign litProd  = {16'h0000, baseVal} * {27'h0000000, shortLiteral};

   // fractional mode doubles the product before it reaches the accumulator
   assign usScaled = fracMode ? {usProd[31:0], 1'b0} : usProd;
   assign accVal   = {{(ACC_W-33){usScaled[32]}}, usScaled};

   // -------------------------------------------------------------------
   // next-state computation
   // -------------------------------------------------------------------

   logic              nxt_wrLoEn;
   logic [3:0]        nxt_wrLoAddr;
   logic [WORD_W-1:0] nxt_wrLoData;
   logic              nxt_wrHiEn;
   logic [3:0]        nxt_wrHiAddr;
   logic [WORD_W-1:0] nxt_wrHiData;
   logic              nxt_ptrWrEn;
   logic [3:0]        nxt_ptrWrAddr;
   logic [WORD_W-1:0] nxt_ptrWrData;
   logic [ACC_W-1:0]  nxt_accumulator_a;
   logic [ACC_W-1:0]  nxt_accumulator_b;
   logic              nxt_opDone;
   logic              nxt_opIllegal;
   logic [31:0]       pairProd;
   logic              doPair;
   logic              usesSrc;

   // route the product; status word is never touched
   always_comb begin
      pairProd      = 32'h0000_0000;
      doPair        = 1'b0;
      usesSrc       = 1'b0;
      nxt_accumulator_a      = accumulatorA_ff;
      nxt_accumulator_b      = accumulatorB_ff;
      nxt_opDone    = 1'b1;
      nxt_opIllegal = 1'b0;
      case (opKind)
         mmu_pkg::OP_US_PAIR: begin
            pairProd = usProd[31:0];
            doPair   = 1'b1;
            usesSrc  = 1'b1;
         end
         mmu_pkg::OP_UU_PAIR: begin
            pairProd = uuProd;
            doPair   = 1'b1;
            usesSrc  = 1'b1;
         end
         mmu_pkg::OP_UU_LIT: begin
            pairProd = litProd;
            doPair   = 1'b1;
         end
         mmu_pkg::OP_US_ACC: begin
            usesSrc = 1'b1;
            if (accSel) begin
               nxt_accumulator_b = accVal;
            end else begin
               nxt_accumulator_a = accVal;
            end
         end
         mmu_pkg::OP_BAD: begin
            nxt_opDone    = 1'b0;
            nxt_opIllegal = 1'b1;
         end
         default: begin
            nxt_opDone = 1'b0;
         end
      endcase
      // low word to the even register, high word to the next
      nxt_wrLoEn   = doPair;
      nxt_wrLoAddr = destIdx;
      nxt_wrLoData = pairProd[15:0];
      nxt_wrHiEn   = doPair;
      nxt_wrHiAddr = {destIdx[3:1], 1'b1};
      nxt_wrHiData = pairProd[31:16];
      // pointer step of two beside the product write
      nxt_ptrWrEn   = usesSrc && modeUpdates(srcMode);
      nxt_ptrWrAddr = srcIdx;
      if (srcMode == mmu_pkg::AM_POSTINC || srcMode == mmu_pkg::AM_PREINC) begin
         nxt_ptrWrData = srcRegVal + mmu_pkg::PTR_STEP;
      end else begin
         nxt_ptrWrData = srcRegVal - mmu_pkg::PTR_STEP;
      end
   end

   // -------------------------------------------------------------------
   // result registers
   // -------------------------------------------------------------------

   // every result lands one edge after issue
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wrLoEn_ff       <= 1'b0;
         wrLoAddr_ff     <= mmu_pkg::IDX_RST;
         wrLoData_ff     <= mmu_pkg::WORD_RST;
         wrHiEn_ff       <= 1'b0;
         wrHiAddr_ff     <= mmu_pkg::IDX_RST;
         wrHiData_ff     <= mmu_pkg::WORD_RST;
         ptrWrEn_ff      <= 1'b0;
         ptrWrAddr_ff    <= mmu_pkg::IDX_RST;
         ptrWrData_ff    <= mmu_pkg::WORD_RST;
         accumulatorA_ff <= mmu_pkg::ACC_RST;
         accumulatorB_ff <= mmu_pkg::ACC_RST;
         opDone_ff       <= 1'b0;
         opIllegal_ff    <= 1'b0;
      end else begin
         wrLoEn_ff       <= nxt_wrLoEn;
         wrLoAddr_ff     <= nxt_wrLoAddr;
         wrLoData_ff     <= nxt_wrLoData;
         wrHiEn_ff       <= nxt_wrHiEn;
         wrHiAddr_ff     <= nxt_wrHiAddr;
         wrHiData_ff     <= nxt_wrHiData;
         ptrWrEn_ff      <= nxt_ptrWrEn;
         ptrWrAddr_ff    <= nxt_ptrWrAddr;
         ptrWrData_ff    <= nxt_ptrWrData;
         accumulatorA_ff <= nxt_accumulator_a;
         accumulatorB_ff <= nxt_accumulator_b;
         opDone_ff       <= nxt_opDone;
         opIllegal_ff    <= nxt_opIllegal;
      end
   end

endmodule : mmu_multiplier

/* bench/mmu_core_model.sv */
module mmu_core_model (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         loadEn,
   input  wire logic [3:0]   loadIdx,
   input  wire logic [15:0]  loadVal,
   input  wire logic         loEn,
   input  wire logic [3:0]   loAddr,
   input  wire logic [15:0]  loData,
   input  wire logic         hiEn,
   input  wire logic [3:0]   hiAddr,
   input  wire logic [15:0]  hiData,
   input  wire logic         ptEn,
   input  wire logic [3:0]   ptAddr,
   input  wire logic [15:0]  ptData,
   output logic      [255:0] workRegs
);
   // ------------------------------
   // working register file
   // ------------------------------
   logic [15:0] regs_ff [16];
   logic [15:0] nxt_regs [16];

   // preload, product pair and pointer writes
   always_comb begin
      nxt_regs = regs_ff;
      if (loadEn) nxt_regs[loadIdx] = loadVal;
      if (loEn) nxt_regs[loAddr] = loData;
      if (hiEn) nxt_regs[hiAddr] = hiData;
      if (ptEn) nxt_regs[ptAddr] = ptData;
   end

   // register the file
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) regs_ff <= '{default: 16'h0000};
      else regs_ff <= nxt_regs;
   end

   // flat view for the multiplier
   always_comb begin
      for (int i = 0; i < 16; i++) workRegs[i*16 +: 16] = regs_ff[i];
   end
endmodule : mmu_core_model

/* bench/mmu_multiplier_chk.sv */
module mmu_multiplier_chk (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        instrValid,
   input wire logic [23:0] instrWord,
   input wire logic        wrLoEn_ff,
   input wire logic [3:0]  wrLoAddr_ff,
   input wire logic        wrHiEn_ff,
   input wire logic [3:0]  wrHiAddr_ff,
   input wire logic        ptrWrEn_ff,
   input wire logic [39:0] accumulatorA_ff,
   input wire logic [39:0] accumulatorB_ff,
   input wire logic        opDone_ff,
   input wire logic        opIllegal_ff
);
   // ------------------------------
   // issue decode helpers
   // ------------------------------
   logic       issue;
   logic       accForm;
   logic [2:0] modeF;
   assign issue   = instrValid && (instrWord[23:16] == 8'hB8);
   assign accForm = issue && !instrWord[15] && (instrWord[10:8] == 3'h7);
   assign modeF   = instrWord[6:4];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   pair_both_a: assert property (wrLoEn_ff == wrHiEn_ff)
      else $error("pair write enables differ");
   hi_addr_a: assert property (wrLoEn_ff |-> !wrLoAddr_ff[0] && wrHiAddr_ff == (wrLoAddr_ff | 4'h1))
      else $error("high word address wrong");
   one_cycle_a: assert property (issue |=> opDone_ff ^ opIllegal_ff)
      else $error("no result one cycle after issue");
   no_issue_a: assert property (!issue |=> !opDone_ff && !opIllegal_ff && !wrLoEn_ff)
      else $error("activity without a multiply issue");
   refuse_a: assert property (opIllegal_ff |-> !wrLoEn_ff && !ptrWrEn_ff)
      else $error("refused form still wrote");
   ptr_step_a: assert property (ptrWrEn_ff |-> opDone_ff && $past(modeF) inside {[3'h2:3'h5]})
      else $error("pointer write without update mode");
   accumulator_b_hold_a: assert property (accForm && !instrWord[7] |=> $stable(accumulatorB_ff))
      else $error("unselected accumulator changed");
   accumulator_a_hold_a: assert property (accForm && instrWord[7] |=> $stable(accumulatorA_ff))
      else $error("unselected accumulator changed");
   acc_ext_a: assert property (accumulatorA_ff[39:32] inside {8'h00, 8'hFF})
      else $error("accumulator guard bits not sign copies");

   cover property (ptrWrEn_ff);
   cover property (opIllegal_ff);
   cover property (accForm ##1 opDone_ff);
endmodule : mmu_multiplier_chk

bind mmu_multiplier mmu_multiplier_chk u_chk (.ref_clk, .rst, .instrValid, .instrWord,
   .wrLoEn_ff, .wrLoAddr_ff, .wrHiEn_ff, .wrHiAddr_ff, .ptrWrEn_ff, .accumulatorA_ff,
   .accumulatorB_ff, .opDone_ff, .opIllegal_ff);

/* bench/mmu_multiplier_tb.sv */
module mmu_multiplier_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // stimulus, model and checks
   // ------------------------------
   logic         ref_clk = 1'b0;
   logic         rst = 1'b1;
   logic         instrValid = 1'b0;
   logic [23:0]  instrWord = 24'h000000;
   logic [15:0]  srcMemData = 16'h0000;
   logic [15:0]  coreControlReg = 16'h0000;
   logic [1:0]   multiplierSignMode = 2'h0;
   logic         loadEn = 1'b0;
   logic [3:0]   loadIdx = 4'h0;
   logic [15:0]  loadVal = 16'h0000;
   logic [255:0] workRegs;
   logic         wrLoEn_ff, wrHiEn_ff, ptrWrEn_ff, opDone_ff, opIllegal_ff;
   logic [3:0]   wrLoAddr_ff, wrHiAddr_ff, ptrWrAddr_ff;
   logic [15:0]  wrLoData_ff, wrHiData_ff, ptrWrData_ff;
   logic [39:0]  accumulatorA_ff, accumulatorB_ff;
   int           err_total = 0;
   int           checks_done = 0;
   int           seed = 2180;
   logic [23:0]  rndWord;
   logic [23:0]  corner [11] = '{24'hB81A35, 24'hB8387F, 24'hB81660, 24'hB88180, 24'hB88700,
                               24'hB80711, 24'hB80791, 24'hB80760, 24'hB98111, 24'hB80711,
                               24'hB80791};

   always #5 ref_clk = ~ref_clk;

   mmu_multiplier dut (.ref_clk, .rst, .instrValid, .instrWord, .workRegs, .srcMemData,
      .coreControlReg, .multiplierSignMode, .wrLoEn_ff, .wrLoAddr_ff, .wrLoData_ff, .wrHiEn_ff,
      .wrHiAddr_ff, .wrHiData_ff, .ptrWrEn_ff, .ptrWrAddr_ff, .ptrWrData_ff, .accumulatorA_ff,
      .accumulatorB_ff, .opDone_ff, .opIllegal_ff);
   mmu_core_model model (.ref_clk, .rst, .loadEn, .loadIdx, .loadVal, .loEn(wrLoEn_ff),
      .loAddr(wrLoAddr_ff), .loData(wrLoData_ff), .hiEn(wrHiEn_ff), .hiAddr(wrHiAddr_ff),
      .hiData(wrHiData_ff), .ptEn(ptrWrEn_ff), .ptAddr(ptrWrAddr_ff), .ptData(ptrWrData_ff),
      .workRegs);

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   // issue one word at a falling edge, check the result one cycle later
   task automatic run(input logic [23:0] word, input logic [15:0] mem, input logic frac);
      logic [15:0] b, ws, src;
      logic signed [32:0] sp;
      logic [31:0] prod;
      logic [39:0] acc, keepA, keepB;
      logic accF, litF, bad, nop, pe;
      b = workRegs[word[14:11]*16 +: 16];
      ws = workRegs[word[3:0]*16 +: 16];
      src = (word[6:4] == 3'h0) ? ws : mem;
      sp = $signed({1'b0, b}) * $signed(src);
      nop = word[23:16] !== 8'hB8;
      accF = !word[15] && word[10:8] == 3'h7;
      litF = !word[15] && !accF && word[6:5] == 2'h3;
      prod = word[15] ? sp[31:0] : (litF ? b * word[4:0] : b * src);
      acc = sp;
      acc = frac ? acc << 1 : acc;
      bad = (!accF && (word[7] || word[10:7] > 4'hC)) || (!litF && word[6:4] > 3'h5);
      pe = !nop && !bad && !litF && word[6:4] inside {[3'h2:3'h5]};
      keepA = accumulatorA_ff;
      keepB = accumulatorB_ff;
      instrValid = 1'b1;
      instrWord = word;
      srcMemData = mem;
      coreControlReg = {16'($random(seed)) & 16'hFFFE} | {15'h0000, frac};
      multiplierSignMode = 2'($random(seed));
      @(negedge ref_clk);
      if (nop || bad) begin
         check("refused", {opDone_ff, opIllegal_ff, wrLoEn_ff, ptrWrEn_ff}, {2'b01 & {1'b0, !nop}, 2'b00});
      end else if (accF) begin
         check("accumulator_a", accumulatorA_ff, word[7] ? keepA : acc);
         check("accumulator_b", accumulatorB_ff, word[7] ? acc : keepB);
      end else begin
         check("low", {wrLoEn_ff, wrLoAddr_ff, wrLoData_ff}, {1'b1, word[10:7], prod[15:0]});
         check("high", {wrHiEn_ff, wrHiAddr_ff, wrHiData_ff}, {1'b1, word[10:8], 1'b1, prod[31:16]});
      end
      check("done", opDone_ff, !nop && !bad);
      check("ptr", ptrWrEn_ff ? {1'b1, ptrWrAddr_ff, ptrWrData_ff} : 21'h0,
         pe ? {1'b1, word[3:0], ws + (word[4] ? 16'h0002 : 16'hFFFE)} : 21'h0);
   endtask : run

   // watchdog against a hang
   initial begin
      #200us;
      err_total++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      for (int i = 0; i < 17; i++) begin
         @(negedge ref_clk);
         loadEn = (i < 16);
         loadIdx = i < 2 ? 4'(i) : 4'(i);
         loadVal = i == 0 ? 16'hC000 : (i == 1 ? 16'h2300 : 16'($random(seed)));
      end
      run(24'hB88111, 16'hF000, 1'b0);
      check("example", {wrHiData_ff, wrLoData_ff}, 32'hF400_0000);
      for (int m = 0; m < 8; m++) run({16'hB884, 1'b0, 3'(m), 4'h2}, 16'($random(seed)), 1'b0);
      for (int i = 0; i < 11; i++) run(corner[i], 16'($random(seed)), i[0]);
      $display("test corner cases done");
      for (int i = 0; i < 60; i++) begin
         rndWord = 24'($random(seed));
         run({8'hB8, rndWord[15:11], i[0] ? rndWord[10:7] : 4'(2 * (i % 7)), rndWord[6:0]},
            16'($random(seed)), rndWord[20]);
      end
      instrValid = 1'b0;
      @(negedge ref_clk);
      $display("test random operations done");
      complete_run();
   end
endmodule : mmu_multiplier_tb
